// *** common/ivr_consts.svh ***
/*
 * Constants of the interrupt vector and priority resolver: vector numbers,
 * source and register counts, writable-bit masks, reset values and levels.
 * Assumes it is included by bare name and holds definitions only.
 */
`ifndef IVR_CONSTS_SVH
`define IVR_CONSTS_SVH

`define IVR_NUM_SRC      35
`define IVR_NUM_PRI_REGS 8
`define IVR_PRI_RESET    16'h0000
`define IVR_NMI_LEVEL    5'h10
`define IVR_NMI_MASK     4'hf
`define IVR_VEC_NMI      8'h0b
`define IVR_VEC_PIN0     8'h40
`define IVR_VEC_PIN6     8'h46
`define IVR_VEC_DMA0     8'h48
`define IVR_VEC_DMA1     8'h4c
`define IVR_VEC_TMR0     8'h58
`define IVR_VEC_TMR1     8'h60
`define IVR_VEC_TMR1_OV  8'h64
`define IVR_VEC_TMR2     8'h68
`define IVR_VEC_TMR2_OV  8'h6c
`define IVR_VEC_SER0     8'h80
`define IVR_VEC_CONV_A   8'h88
`define IVR_VEC_CONV_B   8'h8a
`define IVR_VEC_CMP0     8'h90
`define IVR_VEC_CMP1     8'h94
`define IVR_VEC_WATCHDOG 8'h98
`define IVR_VEC_BUSREF   8'h99

// writable bits per priority register; reserved groups read as zero
`define IVR_WMASK_A 16'hffff
`define IVR_WMASK_B 16'h00ff
`define IVR_WMASK_C 16'hff00
`define IVR_WMASK_D 16'hffff
`define IVR_WMASK_E 16'hff00
`define IVR_WMASK_F 16'h00ff
`define IVR_WMASK_G 16'hf0ff
`define IVR_WMASK_H 16'hf000

`endif

// *** common/ivr_pkg.sv ***
/*
 * Types shared by the interrupt vector and priority resolver.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package ivr_pkg;
    typedef logic [5:0]  ivr_src_t;
    typedef logic [4:0]  ivr_lvl_t;
    typedef logic [7:0]  ivr_vec_t;
    typedef logic [4:0]  ivr_fld_t;
endpackage
`default_nettype wire

// *** dv/ivr_cpu_model.sv ***
/*
 * Cpu-side partner of the resolver: takes the presented request after a
 * wait chosen by the bench, with one accept pulse per request.
 * Assumes the resolver outputs are registered on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
module ivr_cpu_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // resolver side
    input  wire logic       int_req,
    input  wire logic [1:0] ack_wait,
    output logic            cpu_ack
);
    logic [2:0] cnt_r;
    logic       pend_r;
    // idle three cycles after each accept: the source drops its request late,
    // and a stale request must never be taken twice
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r   <= 3'h0;
            pend_r  <= 1'b0;
            cpu_ack <= 1'b0;
        end else if (cpu_ack) begin
            cpu_ack <= 1'b0;
            cnt_r   <= 3'h3;
        end else if (cnt_r != 3'h0) begin
            cnt_r <= cnt_r - 3'h1;
        end else if (pend_r) begin
            pend_r  <= 1'b0;
            cpu_ack <= int_req;
        end else if (int_req) begin
            pend_r <= 1'b1;
            cnt_r  <= {1'b0, ack_wait};
        end
    end
endmodule
`default_nettype wire

// *** dv/ivr_resolver_bench.sv ***
/*
 * Self-checking bench of the interrupt vector and priority resolver.
 * Assumes the resolver, its constants header and the cpu model are compiled.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ivr_consts.svh"
module ivr_resolver_bench;
    logic        mclk, nrst, wr_en, cpu_ack, int_req, ack_stb;
    logic [34:0] req;
    logic [2:0]  wr_sel, rd_sel;
    logic [15:0] wr_data, rd_data;
    logic [3:0]  cpu_mask, new_mask;
    logic [31:0] vbr, fetch;
    logic [4:0]  int_level;
    logic [7:0]  int_vector;
    logic [9:0]  int_off;
    logic [5:0]  ack_src;
    logic [1:0]  ack_wait;
    logic [41:0] exp_q[$];
    logic [41:0] e;
    logic [15:0] pri[8];
    int          err_count, checks_done, seed;
    logic [15:0] wmask[8] = '{`IVR_WMASK_A, `IVR_WMASK_B, `IVR_WMASK_C, `IVR_WMASK_D,
                              `IVR_WMASK_E, `IVR_WMASK_F, `IVR_WMASK_G, `IVR_WMASK_H};
    logic [7:0]  vt[35] = '{8'h0b, 8'h40, 8'h41, 8'h42, 8'h43, 8'h46, 8'h47, 8'h48, 8'h4c,
        8'h58, 8'h59, 8'h5a, 8'h5b, 8'h5c, 8'h60, 8'h61, 8'h64, 8'h65, 8'h68, 8'h69, 8'h6c,
        8'h6d, 8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h90, 8'h94,
        8'h98, 8'h99};
    // field of each source as register index and group
    logic [4:0]  ft[35] = '{5'h00, 5'h03, 5'h02, 5'h01, 5'h00, 5'h05, 5'h04, 5'h0b, 5'h0a,
        5'h0f, 5'h0f, 5'h0f, 5'h0f, 5'h0e, 5'h0d, 5'h0d, 5'h0c, 5'h0c, 5'h13, 5'h13, 5'h12,
        5'h12, 5'h15, 5'h15, 5'h15, 5'h15, 5'h14, 5'h14, 5'h14, 5'h14, 5'h1b, 5'h19, 5'h18,
        5'h1f, 5'h1f};

    ivr_resolver DUT (.MCLK(mclk), .NRST(nrst), .NMI_REQ(req[0]), .IRQ_REQ(req[6:1]),
        .DMA_END_REQ(req[8:7]), .TIMER0_REQ(req[13:9]), .TIMER1_REQ(req[17:14]),
        .TIMER2_REQ(req[21:18]), .SERIAL0_REQ(req[25:22]), .SERIAL1_REQ(req[29:26]),
        .CONV_END_REQ(req[30]), .COMPARE_TIMER_REQ(req[32:31]), .WATCHDOG_REQ(req[33]),
        .BUS_REFRESH_REQ(req[34]), .PRI_WR_EN(wr_en), .PRI_WR_SEL(wr_sel),
        .PRI_WR_DATA(wr_data), .PRI_RD_SEL(rd_sel), .PRI_RD_DATA(rd_data),
        .CPU_MASK(cpu_mask), .VBR(vbr), .CPU_ACK(cpu_ack), .INT_REQ(int_req),
        .INT_LEVEL(int_level), .INT_VECTOR(int_vector), .INT_VEC_OFFSET(int_off),
        .ACK_STB(ack_stb), .ACK_SRC(ack_src), .NEW_MASK(new_mask), .FETCH_ADDR(fetch));
    ivr_cpu_model cpu (.clk(mclk), .rst_n(nrst), .int_req(int_req), .ack_wait(ack_wait),
        .cpu_ack(cpu_ack));

    function automatic int lv(int i);
        return (i == 0) ? 16 : int'(pri[ft[i][4:2]][ft[i][1:0] * 4 +: 4]);
    endfunction
    // highest level above the mask wins, ties go to the lower index
    function automatic int best();
        int w;
        w = -1;
        for (int i = 34; i >= 0; i--)
            if (req[i] && (i == 0 || lv(i) > cpu_mask) && (w < 0 || lv(i) >= lv(w)))
                w = i;
        return w;
    endfunction
    task automatic chk(string n, logic [31:0] x, logic [31:0] g);
        checks_done++;
        if (g !== x) begin
            err_count++;
            $display("[ERR] %s exp %0h got %0h", n, x, g);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic do_reset();
        @(negedge mclk);
        nrst = 1'b0;
        for (int s = 0; s < 8; s++)
            pri[s] = 16'h0;
        exp_q.delete();
        repeat (16) @(negedge mclk);
        nrst = 1'b1;
    endtask
    task automatic wr(int s, logic [15:0] d);
        @(negedge mclk);
        wr_en = 1'b1;
        wr_sel = s[2:0];
        wr_data = d;
        pri[s] = d & wmask[s];
        @(negedge mclk);
        wr_en = 1'b0;
    endtask
    task automatic rd(int s);
        @(negedge mclk);
        rd_sel = s[2:0];
        @(negedge mclk);
        chk("pri_rd", {16'h0, pri[s]}, {16'h0, rd_data});
    endtask
    // present, accept and drop the winner until nothing is presented
    task automatic drain();
        int w, k;
        forever begin
            w = best();
            ack_wait = 2'($random(seed));
            @(negedge mclk);
            if (w < 0) begin
                chk("idle", 32'h0, {31'h0, int_req});
                req = '0;
                return;
            end
            chk("int_req", 32'h1, {31'h0, int_req});
            chk("level", lv(w), {27'h0, int_level});
            chk("vector", {24'h0, vt[w]}, {24'h0, int_vector});
            chk("offset", vt[w] * 4, {22'h0, int_off});
            exp_q.push_back({6'(w), (w == 0) ? 4'hf : 4'(lv(w)), vbr + vt[w] * 4});
            for (k = 0; k < 20 && ack_stb !== 1'b1; k++)
                @(negedge mclk);
            chk("ack_stb", 32'h1, {31'h0, ack_stb});
            req[w] = 1'b0;
        end
    endtask

    always @(negedge mclk)
        if (nrst && ack_stb === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("spare_ack", 32'h0, 32'h1);
            end else begin
                e = exp_q.pop_front();
                chk("ack_src", {26'h0, e[41:36]}, {26'h0, ack_src});
                chk("new_mask", {28'h0, e[35:32]}, {28'h0, new_mask});
                chk("fetch", e[31:0], fetch);
            end
        end
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        #400000;
        err_count++;
        $display("[ERR] watchdog exp finish got hang");
        tally_and_finish();
    end
    initial begin
        seed = 32'hfacc;
        {nrst, req, wr_en, wr_sel, wr_data, rd_sel, cpu_mask, vbr, ack_wait} = '0;
        do_reset();
        for (int s = 0; s < 8; s++)
            rd(s);
        req = ~35'h1;
        drain();
        $display("test reset_values done");
        for (int s = 0; s < 8; s++) begin
            wr(s, 16'hffff);
            rd(s);
        end
        req = ~35'h0;
        drain();
        $display("test equal_levels done");
        req = 35'h6;
        drain();
        req = 35'h2;
        drain();
        $display("test pin_pair done");
        cpu_mask = 4'hf;
        req = ~35'h0;
        drain();
        $display("test nmi_over_mask done");
        repeat (6) begin
            for (int s = 0; s < 8; s++)
                wr(s, 16'($random(seed)));
            cpu_mask = 4'($random(seed)) & 4'h3;
            vbr = $random(seed) & 32'hffff_fffc;
            req = {3'($random(seed)), 32'($random(seed))};
            drain();
        end
        $display("test random_levels done");
        do_reset();
        for (int s = 0; s < 8; s++)
            rd(s);
        req = ~35'h0;
        drain();
        $display("test second_reset done");
        tally_and_finish();
    end
endmodule
`default_nettype wire

// *** rtl/ivr_resolver.sv ***
/*
 * Interrupt vector and priority resolver: holds eight priority registers,
 * ranks pending sources and presents the winner with its vector to the cpu.
 * Assumes request inputs are already detected (edge or level) and synchronous
 * to MCLK, and that each source drops its request once serviced.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ivr_consts.svh"
module ivr_resolver #(
    parameter logic [7:0] CONV_VECTOR = `IVR_VEC_CONV_A
) (
    // clock and reset
    input  wire logic        MCLK,
    input  wire logic        NRST,
    // request inputs
    input  wire logic        NMI_REQ,
    input  wire logic [5:0]  IRQ_REQ,
    input  wire logic [1:0]  DMA_END_REQ,
    input  wire logic [4:0]  TIMER0_REQ,
    input  wire logic [3:0]  TIMER1_REQ,
    input  wire logic [3:0]  TIMER2_REQ,
    input  wire logic [3:0]  SERIAL0_REQ,
    input  wire logic [3:0]  SERIAL1_REQ,
    input  wire logic        CONV_END_REQ,
    input  wire logic [1:0]  COMPARE_TIMER_REQ,
    input  wire logic        WATCHDOG_REQ,
    input  wire logic        BUS_REFRESH_REQ,
    // priority register access
    input  wire logic        PRI_WR_EN,
    input  wire logic [2:0]  PRI_WR_SEL,
    input  wire logic [15:0] PRI_WR_DATA,
    input  wire logic [2:0]  PRI_RD_SEL,
    output logic      [15:0] PRI_RD_DATA,
    // cpu side
    input  wire logic [3:0]  CPU_MASK,
    input  wire logic [31:0] VBR,
    input  wire logic        CPU_ACK,
    output logic             INT_REQ,
    output logic      [4:0]  INT_LEVEL,
    output logic      [7:0]  INT_VECTOR,
    output logic      [9:0]  INT_VEC_OFFSET,
    output logic             ACK_STB,
    output logic      [5:0]  ACK_SRC,
    output logic      [3:0]  NEW_MASK,
    output logic      [31:0] FETCH_ADDR
);

    // source index order is the default order, ascending by vector
    function automatic ivr_pkg::ivr_vec_t src_vec(input ivr_pkg::ivr_src_t s);
        ivr_pkg::ivr_vec_t v;
        v = `IVR_VEC_NMI;
        if (s >= 6'd1 && s <= 6'd4) v = `IVR_VEC_PIN0 + 8'(s - 6'd1);
        else if (s == 6'd5 || s == 6'd6) v = `IVR_VEC_PIN6 + 8'(s - 6'd5);
        else if (s == 6'd7) v = `IVR_VEC_DMA0;
        else if (s == 6'd8) v = `IVR_VEC_DMA1;
        else if (s >= 6'd9 && s <= 6'd13) v = `IVR_VEC_TMR0 + 8'(s - 6'd9);
        else if (s == 6'd14 || s == 6'd15) v = `IVR_VEC_TMR1 + 8'(s - 6'd14);
        else if (s == 6'd16 || s == 6'd17) v = `IVR_VEC_TMR1_OV + 8'(s - 6'd16);
        else if (s == 6'd18 || s == 6'd19) v = `IVR_VEC_TMR2 + 8'(s - 6'd18);
        else if (s == 6'd20 || s == 6'd21) v = `IVR_VEC_TMR2_OV + 8'(s - 6'd20);
        else if (s >= 6'd22 && s <= 6'd29) v = `IVR_VEC_SER0 + 8'(s - 6'd22);
        else if (s == 6'd30) v = CONV_VECTOR;
        else if (s == 6'd31) v = `IVR_VEC_CMP0;
        else if (s == 6'd32) v = `IVR_VEC_CMP1;
        else if (s == 6'd33) v = `IVR_VEC_WATCHDOG;
        else if (s == 6'd34) v = `IVR_VEC_BUSREF;
        return v;
    endfunction

    // {register, group}; group 3 is bits 15:12, group 0 is bits 3:0
    function automatic ivr_pkg::ivr_fld_t src_field(input ivr_pkg::ivr_src_t s);
        ivr_pkg::ivr_fld_t f;
        f = 5'h00;
        case (s)
            6'd1:  f = {3'd0, 2'd3};
            6'd2:  f = {3'd0, 2'd2};
            6'd3:  f = {3'd0, 2'd1};
            6'd4:  f = {3'd0, 2'd0};
            6'd5:  f = {3'd1, 2'd1};
            6'd6:  f = {3'd1, 2'd0};
            6'd7:  f = {3'd2, 2'd3};
            6'd8:  f = {3'd2, 2'd2};
            6'd9, 6'd10, 6'd11, 6'd12: f = {3'd3, 2'd3};
            6'd13: f = {3'd3, 2'd2};
            6'd14, 6'd15: f = {3'd3, 2'd1};
            6'd16, 6'd17: f = {3'd3, 2'd0};
            6'd18, 6'd19: f = {3'd4, 2'd3};
            6'd20, 6'd21: f = {3'd4, 2'd2};
            6'd22, 6'd23, 6'd24, 6'd25: f = {3'd5, 2'd1};
            6'd26, 6'd27, 6'd28, 6'd29: f = {3'd5, 2'd0};
            6'd30: f = {3'd6, 2'd3};
            6'd31: f = {3'd6, 2'd1};
            6'd32: f = {3'd6, 2'd0};
            6'd33, 6'd34: f = {3'd7, 2'd3};
            default: f = 5'h00;
        endcase
        return f;
    endfunction

    logic [15:0]              pri_r [`IVR_NUM_PRI_REGS];
    logic [15:0]              wmask;
    logic [`IVR_NUM_SRC-1:0]  req;
    ivr_pkg::ivr_lvl_t        best_lvl;
    ivr_pkg::ivr_src_t        best_idx;
    logic                     present;
    logic                     int_req_r;
    ivr_pkg::ivr_lvl_t        int_lvl_r;
    ivr_pkg::ivr_vec_t        int_vec_r;
    ivr_pkg::ivr_src_t        int_src_r;
    logic                     ack_stb_r;
    ivr_pkg::ivr_src_t        ack_src_r;
    logic [3:0]               new_mask_r;
    logic [31:0]              fetch_addr_r;
    logic [15:0]              rd_data_r;

    assign req = {BUS_REFRESH_REQ, WATCHDOG_REQ, COMPARE_TIMER_REQ, CONV_END_REQ,
                  SERIAL1_REQ, SERIAL0_REQ, TIMER2_REQ, TIMER1_REQ, TIMER0_REQ,
                  DMA_END_REQ, IRQ_REQ, NMI_REQ};

    always_comb begin
        case (PRI_WR_SEL)
            3'd0:    wmask = `IVR_WMASK_A;
            3'd1:    wmask = `IVR_WMASK_B;
            3'd2:    wmask = `IVR_WMASK_C;
            3'd3:    wmask = `IVR_WMASK_D;
            3'd4:    wmask = `IVR_WMASK_E;
            3'd5:    wmask = `IVR_WMASK_F;
            3'd6:    wmask = `IVR_WMASK_G;
            default: wmask = `IVR_WMASK_H;
        endcase
    end

    // reserved groups are never stored, so they can never raise a level
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            for (int r = 0; r < `IVR_NUM_PRI_REGS; r++) begin
                pri_r[r] <= `IVR_PRI_RESET;
            end
        end else if (PRI_WR_EN) begin
            pri_r[PRI_WR_SEL] <= PRI_WR_DATA & wmask;
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            rd_data_r <= 16'h0000;
        end else begin
            rd_data_r <= pri_r[PRI_RD_SEL];
        end
    end

    // strict greater-than in ascending index order keeps the lowest vector
    // on a tie, which is also the fixed order inside a shared field
    always_comb begin
        ivr_pkg::ivr_fld_t f;
        ivr_pkg::ivr_lvl_t l;
        f = 5'h00;
        l = 5'h00;
        best_lvl = 5'h00;
        best_idx = 6'h00;
        for (int i = 0; i < `IVR_NUM_SRC; i++) begin
            f = src_field(6'(i));
            if (i == 0) l = `IVR_NMI_LEVEL;
            else l = {1'b0, pri_r[f[4:2]][{f[1:0], 2'b00} +: 4]};
            if (req[i] && l > best_lvl) begin
                best_lvl = l;
                best_idx = 6'(i);
            end
        end
    end

    assign present = (best_lvl != 5'h00) &&
                     (best_idx == 6'h00 || best_lvl > {1'b0, CPU_MASK});

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            int_req_r <= 1'b0;
            int_lvl_r <= 5'h00;
            int_vec_r <= 8'h00;
            int_src_r <= 6'h00;
        end else begin
            int_req_r <= present;
            int_lvl_r <= present ? best_lvl : 5'h00;
            int_vec_r <= present ? src_vec(best_idx) : 8'h00;
            int_src_r <= best_idx;
        end
    end

    // accept captures what the cpu saw last cycle, not the live winner
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            ack_stb_r    <= 1'b0;
            ack_src_r    <= 6'h00;
            new_mask_r   <= 4'h0;
            fetch_addr_r <= 32'h0000_0000;
        end else begin
            ack_stb_r <= CPU_ACK && int_req_r;
            if (CPU_ACK && int_req_r) begin
                ack_src_r    <= int_src_r;
                new_mask_r   <= (int_src_r == 6'h00) ? `IVR_NMI_MASK : int_lvl_r[3:0];
                fetch_addr_r <= VBR + {22'h000000, int_vec_r, 2'b00};
            end
        end
    end

    assign PRI_RD_DATA    = rd_data_r;
    assign INT_REQ        = int_req_r;
    assign INT_LEVEL      = int_lvl_r;
    assign INT_VECTOR     = int_vec_r;
    assign INT_VEC_OFFSET = {int_vec_r, 2'b00};
    assign ACK_STB        = ack_stb_r;
    assign ACK_SRC        = ack_src_r;
    assign NEW_MASK       = new_mask_r;
    assign FETCH_ADDR     = fetch_addr_r;

    sequence s_accept;
        CPU_ACK && INT_REQ;
    endsequence

    sequence s_only_watchdog_pair;
        WATCHDOG_REQ && BUS_REFRESH_REQ && (req[32:0] == 33'h0) && pri_r[7][15:12] > CPU_MASK;
    endsequence

    a_nmi_always_wins: assert property (@(posedge MCLK) disable iff (!NRST)
        NMI_REQ |=> INT_REQ && INT_VECTOR == 8'h0b && INT_LEVEL == 5'h10)
        else $error("non-maskable request not presented at level 16");
    a_offset_times_four: assert property (@(posedge MCLK) disable iff (!NRST)
        INT_VEC_OFFSET == 10'(INT_VECTOR) * 10'd4)
        else $error("vector offset is not four times the vector");
    a_below_mask_held: assert property (@(posedge MCLK) disable iff (!NRST)
        (!NMI_REQ && best_lvl <= {1'b0, CPU_MASK}) |=> !INT_REQ)
        else $error("request presented at or below cpu mask");
    a_level_zero_masked: assert property (@(posedge MCLK) disable iff (!NRST)
        INT_REQ |-> INT_LEVEL != 5'h00)
        else $error("level zero request reached the cpu");
    a_accept_mask_load: assert property (@(posedge MCLK) disable iff (!NRST)
        s_accept |=> ACK_STB &&
            NEW_MASK == (($past(INT_VECTOR) == 8'h0b) ? 4'hf : $past(INT_LEVEL[3:0])))
        else $error("accepted mask level wrong");
    a_fetch_address: assert property (@(posedge MCLK) disable iff (!NRST)
        s_accept |=> FETCH_ADDR == $past(VBR) + {22'h0, $past(INT_VECTOR), 2'b00})
        else $error("fetch address not from selected table entry");
    a_watchdog_first: assert property (@(posedge MCLK) disable iff (!NRST)
        s_only_watchdog_pair |=> INT_VECTOR == 8'h98)
        else $error("watchdog did not precede bus controller");
    a_pin0_level: assert property (@(posedge MCLK) disable iff (!NRST)
        (IRQ_REQ[0] && req == 35'h2 && pri_r[0][15:12] > CPU_MASK)
            |=> INT_VECTOR == 8'h40 && INT_LEVEL == {1'b0, $past(pri_r[0][15:12])})
        else $error("pin 0 not presented with its field level");
    a_tie_lower_vector: assert property (@(posedge MCLK) disable iff (!NRST)
        (req == 35'h6 && pri_r[0][15:12] == pri_r[0][11:8] && pri_r[0][11:8] > CPU_MASK)
            |=> INT_VECTOR == 8'h40)
        else $error("tie not resolved to lower vector");
    a_ack_one_cycle: assert property (@(posedge MCLK) disable iff (!NRST)
        ACK_STB |-> $past(CPU_ACK) && $past(INT_REQ) ##1 !ACK_STB || $past(CPU_ACK))
        else $error("accept strobe without accept");

endmodule
`default_nettype wire
